// ---- rtl/uart_ctl.sv ----
// Interrupt identification, enables, scratch, FIFO control and modem control of the serial transceiver
`timescale 1ns/100ps
`include "uart_ctl_cfg.svh"

module uart_ctl #(
   parameter int FIFO_DEPTH    = 16,
   parameter int CNT_W         = 5,
   parameter int RCLK_PER_CHAR = `RCLK_PER_CHAR
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // Register port
   input  wire logic [2:0]              addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [7:0]              rdata,
   // Receive and transmit data path, line and modem status
   input  wire logic [7:0]              rx_data,
   input  wire logic [CNT_W-1:0]        rx_fifo_count,
   input  wire logic                    rx_data_ready,
   input  wire logic                    rx_push,
   input  wire logic                    line_error,
   input  wire logic [7:0]              line_status_reg,
   input  wire logic                    thr_empty,
   input  wire logic [7:0]              modem_status_reg,
   input  wire logic                    rclk_en,
   // Modem handshake inputs, active low pins
   input  wire logic                    cts_n,
   input  wire logic                    dsr_n,
   input  wire logic                    ri_n,
   input  wire logic                    carrier_detect_input_n,
   // Modem status seen by the status logic
   output logic      [3:0]              modem_in_level,
   // Serial lines
   input  wire logic                    serial_rx_line,
   input  wire logic                    tx_shift_out,
   output logic                         serial_tx_line,
   output logic                         rx_shift_in,
   // FIFO and DMA control
   output logic                         fifo_enable,
   output logic                         rx_fifo_reset,
   output logic                         tx_fifo_reset,
   output logic                         dma_mode_select,
   output logic                         trigger_reached,
   // Modem outputs and interrupt
   output uart_ctl_pkg::modem_out_t     modem_out,
   output logic                         irq_output
);

   uart_ctl_pkg::bus_req_t req;
   uart_ctl_pkg::irq_src_t src;

   logic [3:0] int_enable_reg_q;
   logic [7:0] fifo_ctrl_reg_q;
   logic [4:0] modem_ctrl_reg_q;
   logic [7:0] scratch_q;
   logic       rx_fifo_reset_q;
   logic       tx_fifo_reset_q;
   logic       thre_pend_q;
   logic       thre_empty_q;
   logic       rls_pend_q;
   logic [7:0] rdata_q;
   logic [7:0] char_tick_q;
   logic [2:0] idle_chars_q;
   logic       cto_pend_q;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Address decode
   function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
      return a == target;
   endfunction

   wire wr_ier  = req.wr && hit(req.addr, `ADDR_IER);
   wire wr_fcr  = req.wr && hit(req.addr, `ADDR_IIR_FCR);
   wire wr_mcr  = req.wr && hit(req.addr, `ADDR_MCR);
   wire wr_scr  = req.wr && hit(req.addr, `ADDR_SCR);
   wire wr_thr  = req.wr && hit(req.addr, `ADDR_RBR_THR);
   wire rd_rbr  = req.rd && hit(req.addr, `ADDR_RBR_THR);
   wire rd_iir  = req.rd && hit(req.addr, `ADDR_IIR_FCR);
   wire rd_lsr  = req.rd && hit(req.addr, `ADDR_LSR);
   wire rd_msr  = req.rd && hit(req.addr, `ADDR_MSR);

   wire loop    = modem_ctrl_reg_q[`MCR_LOOP_BIT];
   wire fifo_on = fifo_ctrl_reg_q[`FCR_EN_BIT];

   // Trigger level decode
   logic [4:0] trig_lvl;
   always_comb begin
      unique case (fifo_ctrl_reg_q[7:6])
         2'h0: trig_lvl = `TRIG_LVL0;
         2'h1: trig_lvl = `TRIG_LVL1;
         2'h2: trig_lvl = `TRIG_LVL2;
         2'h3: trig_lvl = `TRIG_LVL3;
      endcase
   end

   assign trigger_reached = fifo_on && (5'(rx_fifo_count) >= trig_lvl);

   // Source conditions
   wire rda_cond  = fifo_on ? trigger_reached : rx_data_ready;
   wire msr_cond  = |modem_status_reg[3:0];
   wire rls_en    = int_enable_reg_q[2] && rls_pend_q;
   wire rda_en    = int_enable_reg_q[0] && rda_cond;
   wire cto_en    = int_enable_reg_q[0] && fifo_on && cto_pend_q;
   wire thre_en   = int_enable_reg_q[1] && thre_pend_q;
   wire msr_en    = int_enable_reg_q[3] && msr_cond;

   // Priority encoder
   always_comb begin
      if (rls_en)
         src = uart_ctl_pkg::SRC_RLS;
      else if (rda_en || cto_en)
         src = uart_ctl_pkg::SRC_RDA;
      else if (thre_en)
         src = uart_ctl_pkg::SRC_THRE;
      else if (msr_en)
         src = uart_ctl_pkg::SRC_MSR;
      else
         src = uart_ctl_pkg::SRC_NONE;
   end

   logic [3:0] iid;
   always_comb begin
      unique case (src)
         uart_ctl_pkg::SRC_RLS:  iid = `IID_RLS;
         uart_ctl_pkg::SRC_RDA:  iid = rda_en ? `IID_RDA : `IID_CTO;
         uart_ctl_pkg::SRC_THRE: iid = `IID_THRE;
         uart_ctl_pkg::SRC_MSR:  iid = `IID_MSR;
         default:                iid = `IID_NONE;
      endcase
   end

   wire [7:0] int_ident_reg = {{2{fifo_on}}, 2'h0, iid};

   // Read data mux
   logic [7:0] rd_mux;
   always_comb begin
      unique case (req.addr)
         `ADDR_RBR_THR: rd_mux = rx_data;
         `ADDR_IER:     rd_mux = {4'h0, int_enable_reg_q};
         `ADDR_IIR_FCR: rd_mux = int_ident_reg;
         `ADDR_MCR:     rd_mux = {3'h0, modem_ctrl_reg_q};
         `ADDR_LSR:     rd_mux = line_status_reg;
         `ADDR_MSR:     rd_mux = modem_status_reg;
         `ADDR_SCR:     rd_mux = scratch_q;
         default:       rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         rdata_q <= 8'h00;
      else if (req.rd)
         rdata_q <= rd_mux;
   end
   assign rdata = rdata_q;

   // Writable registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_enable_reg_q <= `IER_RESET;
         modem_ctrl_reg_q <= `MCR_RESET;
         scratch_q        <= `SCR_RESET;
      end else begin
         if (wr_ier)
            int_enable_reg_q <= req.wdata[3:0];
         if (wr_mcr)
            modem_ctrl_reg_q <= req.wdata[4:0];
         if (wr_scr)
            scratch_q <= req.wdata;
      end
   end

   // FIFO control; reset bits never stored, they only pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fifo_ctrl_reg_q <= `FCR_RESET;
         rx_fifo_reset_q <= 1'b0;
         tx_fifo_reset_q <= 1'b0;
      end else begin
         rx_fifo_reset_q <= 1'b0;
         tx_fifo_reset_q <= 1'b0;
         if (wr_fcr) begin
            if (req.wdata[`FCR_EN_BIT]) begin
               fifo_ctrl_reg_q <= {req.wdata[7:6], 2'h0, req.wdata[`FCR_DMA_BIT], 3'h1};
               rx_fifo_reset_q <= req.wdata[`FCR_RXRST_BIT];
               tx_fifo_reset_q <= req.wdata[`FCR_TXRST_BIT];
            end else begin
               fifo_ctrl_reg_q[`FCR_EN_BIT] <= 1'b0;
            end
         end
      end
   end

   assign fifo_enable     = fifo_on;
   assign rx_fifo_reset   = rx_fifo_reset_q;
   assign tx_fifo_reset   = tx_fifo_reset_q;
   assign dma_mode_select = fifo_on && fifo_ctrl_reg_q[`FCR_DMA_BIT];

   // Line status pending; a new error wins over the clearing read
   always_ff @(posedge clk) begin
      if (sys_rst)
         rls_pend_q <= 1'b0;
      else if (line_error)
         rls_pend_q <= 1'b1;
      else if (rd_lsr)
         rls_pend_q <= 1'b0;
   end

   // Transmit empty: set on rising empty, cleared by write or by an ident read while it is the source shown
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thre_pend_q  <= 1'b0;
         // Idle transmitter is empty; a low here would fake an edge after reset
         thre_empty_q <= 1'b1;
      end else begin
         thre_empty_q <= thr_empty;
         if (thr_empty && !thre_empty_q)
            thre_pend_q <= 1'b1;
         else if (wr_thr || (rd_iir && src == uart_ctl_pkg::SRC_THRE))
            thre_pend_q <= 1'b0;
      end
   end

   // Character timeout, counted in receiver clock ticks
   wire fifo_activity = rx_push || rd_rbr || rx_fifo_reset_q;
   wire char_done     = rclk_en && (char_tick_q == 8'(RCLK_PER_CHAR - 1));
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         char_tick_q  <= 8'h00;
         idle_chars_q <= 3'h0;
         cto_pend_q   <= 1'b0;
      end else if (fifo_activity || rx_fifo_count == '0) begin
         char_tick_q  <= 8'h00;
         idle_chars_q <= 3'h0;
         cto_pend_q   <= 1'b0;
      end else if (rclk_en) begin
         char_tick_q <= char_done ? 8'h00 : char_tick_q + 8'h01;
         if (char_done && idle_chars_q != `CTO_CHAR_TIMES)
            idle_chars_q <= idle_chars_q + 3'h1;
         if (idle_chars_q == `CTO_CHAR_TIMES)
            cto_pend_q <= 1'b1;
      end
   end

   // Modem outputs, loopback
   wire [3:0] mc = modem_ctrl_reg_q[3:0];
   always_comb begin
      if (loop)
         modem_out = '{dtr_n: 1'b1, rts_n: 1'b1, aux_a_n: 1'b1, aux_b_n: 1'b1};
      else
         modem_out = '{dtr_n: ~mc[0], rts_n: ~mc[1], aux_a_n: ~mc[2], aux_b_n: ~mc[3]};
   end

   // Modem levels as active-high cts, dsr, ri, dcd
   assign modem_in_level = loop ? {mc[3], mc[2], mc[0], mc[1]}
                                : {~carrier_detect_input_n, ~ri_n, ~dsr_n, ~cts_n};

   assign serial_tx_line = loop ? 1'b1 : tx_shift_out;
   assign rx_shift_in    = loop ? tx_shift_out : serial_rx_line;

   assign irq_output = (src != uart_ctl_pkg::SRC_NONE);

endmodule

// ---- rtl/uart_ctl_cfg.svh ----
// Register offsets, field positions, reset values and timing constants for the serial control block
`ifndef UART_CTL_CFG_SVH
`define UART_CTL_CFG_SVH
`define ADDR_RBR_THR      3'h0
`define ADDR_IER          3'h1
`define ADDR_IIR_FCR      3'h2
`define ADDR_MCR          3'h4
`define ADDR_LSR          3'h5
`define ADDR_MSR          3'h6
`define ADDR_SCR          3'h7
`define IER_RESET         4'h0
`define FCR_RESET         8'h00
`define MCR_RESET         5'h00
`define SCR_RESET         8'h00
`define FCR_EN_BIT        0
`define FCR_RXRST_BIT     1
`define FCR_TXRST_BIT     2
`define FCR_DMA_BIT       3
`define MCR_LOOP_BIT      4
`define IID_NONE          4'h1
`define IID_RLS           4'h6
`define IID_RDA           4'h4
`define IID_CTO           4'hc
`define IID_THRE          4'h2
`define IID_MSR           4'h0
`define TRIG_LVL0         5'h01
`define TRIG_LVL1         5'h04
`define TRIG_LVL2         5'h08
`define TRIG_LVL3         5'h0e
`define CTO_CHAR_TIMES    3'h4
`define RCLK_PER_CHAR     8'ha0
`endif

// ---- rtl/uart_ctl_pkg.sv ----
// Types shared by the serial control block
package uart_ctl_pkg;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      logic dtr_n;
      logic rts_n;
      logic aux_a_n;
      logic aux_b_n;
   } modem_out_t;

   typedef enum logic [4:0] {
      SRC_NONE = 5'b00001,
      SRC_RLS  = 5'b00010,
      SRC_RDA  = 5'b00100,
      SRC_THRE = 5'b01000,
      SRC_MSR  = 5'b10000
   } irq_src_t;
endpackage

// ---- testbench/modem_partner.sv ----
// Modem side model: null-modem handshake answer and serial echo
`timescale 1ns/100ps
module modem_partner (
   // Clock
   input  wire logic                     clk,
   // From the transceiver
   input  wire uart_ctl_pkg::modem_out_t modem_out,
   input  wire logic                     serial_tx_line,
   // To the transceiver
   output logic                          cts_n = 1'b1,
   output logic                          dsr_n = 1'b1,
   output logic                          ri_n,
   output logic                          carrier_detect_input_n,
   output logic                          serial_rx_line = 1'b1
);
   // One cycle of cable delay on every answered line
   always @(posedge clk) begin
      cts_n <= modem_out.rts_n;
      dsr_n <= modem_out.dtr_n;
      serial_rx_line <= serial_tx_line;
   end
   // Ring idle, carrier present
   assign ri_n = 1'b1;
   assign carrier_detect_input_n = 1'b0;
endmodule

// ---- testbench/test_uart_ctl.sv ----
// Self-checking bench for the serial control block
`timescale 1ns/100ps
module test_uart_ctl;
   typedef struct packed {logic w; logic [2:0] a; logic [7:0] d;} row_t;
   logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_data_ready = 1'b0, line_error = 1'b0;
   logic thr_empty = 1'b0, rclk_en = 1'b0, tx_shift_out = 1'b1, rx_push = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, modem_status_reg = 8'h00;
   logic [4:0] rx_fifo_count = 5'h00;
   logic [3:0] modem_in_level;
   logic cts_n, dsr_n, ri_n, carrier_detect_input_n, serial_rx_line, serial_tx_line, rx_shift_in;
   logic fifo_enable, rx_fifo_reset, tx_fifo_reset, dma_mode_select, trigger_reached, irq_output;
   uart_ctl_pkg::modem_out_t modem_out;
   int error_cnt = 0, check_count = 0, cyc = 0;
   row_t rows [17] = '{'{0,1,8'h00}, '{0,2,8'h01}, '{0,4,8'h00}, '{1,7,8'ha5}, '{0,7,8'ha5},
      '{1,1,8'hff}, '{0,1,8'h0f}, '{1,4,8'hff}, '{0,4,8'h1f}, '{1,4,8'h00}, '{0,3,8'h00},
      '{1,2,8'hc1}, '{0,2,8'hc1}, '{1,2,8'h00}, '{0,2,8'h01}, '{1,7,8'h3c}, '{0,7,8'h3c}};
   logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
   always #50 clk = ~clk;
   uart_ctl #(.RCLK_PER_CHAR(4)) dut (.clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .rx_data(8'h3c),
      .rx_fifo_count, .rx_data_ready, .rx_push, .line_error, .line_status_reg(8'h60), .thr_empty,
      .modem_status_reg, .rclk_en, .cts_n, .dsr_n, .ri_n, .carrier_detect_input_n, .modem_in_level,
      .serial_rx_line, .tx_shift_out, .serial_tx_line, .rx_shift_in, .fifo_enable, .rx_fifo_reset,
      .tx_fifo_reset, .dma_mode_select, .trigger_reached, .modem_out, .irq_output);
   modem_partner partner (.clk, .modem_out, .serial_tx_line, .cts_n, .dsr_n, .ri_n,
      .carrier_detect_input_n, .serial_rx_line);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1500) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wreg(rows[i].a, rows[i].d);
         else rreg(rows[i].a, rows[i].d);
      end
      $display("register table done");
      modem_status_reg <= 8'h01;
      rreg(3'h2, 8'h00);
      chk({7'h0, irq_output}, 8'h01);
      thr_empty <= 1'b1;
      rreg(3'h2, 8'h02);
      rreg(3'h2, 8'h00);
      thr_empty <= 1'b0;
      tick(2);
      thr_empty <= 1'b1;
      line_error <= 1'b1;
      tick(1);
      line_error <= 1'b0;
      rreg(3'h2, 8'h06);
      rreg(3'h5, 8'h60);
      rreg(3'h2, 8'h02);
      wreg(3'h0, 8'h55);
      rx_data_ready <= 1'b1;
      rreg(3'h2, 8'h04);
      rx_data_ready <= 1'b0;
      wreg(3'h1, 8'h00);
      rreg(3'h2, 8'h01);
      chk({7'h0, irq_output}, 8'h00);
      wreg(3'h1, 8'h08);
      modem_status_reg <= 8'h00;
      rreg(3'h2, 8'h01);
      $display("priority test done");
      for (int i = 0; i < 4; i++) begin
         wreg(3'h2, {i[1:0], 6'h01});
         rx_fifo_count <= trig[i] - 5'h01;
         tick(2);
         chk({7'h0, trigger_reached}, 8'h00);
         rx_fifo_count <= trig[i];
         tick(2);
         chk({7'h0, trigger_reached}, 8'h01);
      end
      $display("trigger test done");
      wreg(3'h1, 8'h01);
      wreg(3'h2, 8'h41);
      rx_fifo_count <= 5'h01;
      rclk_en <= 1'b1;
      tick(24);
      rreg(3'h2, 8'hcc);
      rreg(3'h0, 8'h3c);
      rreg(3'h2, 8'hc1);
      tick(13);
      chk({7'h0, irq_output}, 8'h00);
      rx_push <= 1'b1;
      tick(1);
      rx_push <= 1'b0;
      tick(16);
      chk({7'h0, irq_output}, 8'h00);
      tick(1);
      chk({7'h0, irq_output}, 8'h01);
      rreg(3'h0, 8'h3c);
      rclk_en <= 1'b0;
      $display("timeout test done");
      wreg(3'h4, 8'h05);
      tick(2);
      chk({4'h0, modem_out}, 8'h05);
      chk({4'h0, modem_in_level}, 8'h0a);
      wreg(3'h4, 8'h1a);
      tx_shift_out <= 1'b0;
      tick(1);
      chk({6'h0, serial_tx_line, rx_shift_in}, 8'h02);
      chk({4'h0, modem_out}, 8'h0f);
      chk({4'h0, modem_in_level}, 8'h09);
      wreg(3'h4, 8'h00);
      tick(2);
      tx_shift_out <= 1'b1;
      #1 chk({6'h0, serial_tx_line, rx_shift_in}, 8'h02);
      wreg(3'h2, 8'h0f);
      #1 chk({4'h0, fifo_enable, rx_fifo_reset, tx_fifo_reset, dma_mode_select}, 8'h0f);
      tick(1);
      chk({4'h0, fifo_enable, rx_fifo_reset, tx_fifo_reset, dma_mode_select}, 8'h09);
      wreg(3'h2, 8'hc6);
      #1 chk({4'h0, fifo_enable, rx_fifo_reset, tx_fifo_reset, dma_mode_select}, 8'h00);
      rreg(3'h2, 8'h01);
      $display("modem and control test done");
      wreg(3'h1, 8'h0f);
      wreg(3'h4, 8'h03);
      wreg(3'h2, 8'h01);
      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      chk({4'h0, modem_out}, 8'h0f);
      rreg(3'h1, 8'h00);
      rreg(3'h4, 8'h00);
      rreg(3'h2, 8'h01);
      wreg(3'h1, 8'h02);
      rreg(3'h2, 8'h01);
      $display("reset test done");
      tally_and_finish;
   end
endmodule

// ---- testbench/uart_ctl_props.sv ----
// Port-level assertions for the serial control block
`timescale 1ns/100ps
module uart_ctl_props (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     sys_rst,
   // Register port
   input wire logic [2:0]               addr,
   input wire logic [7:0]               wdata,
   input wire logic                     wr,
   input wire logic                     rd,
   input wire logic [7:0]               rdata,
   // Outputs watched
   input wire logic                     serial_tx_line,
   input wire logic                     fifo_enable,
   input wire logic                     rx_fifo_reset,
   input wire logic                     tx_fifo_reset,
   input wire logic                     dma_mode_select,
   input wire uart_ctl_pkg::modem_out_t modem_out,
   input wire logic                     irq_output
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire fcr_wr = wr && addr == 3'h2;
   wire mcr_wr = wr && addr == 3'h4;
   wire iir_rd = rd && addr == 3'h2;
   AST_DTR_RTS: assert property (mcr_wr && !wdata[4] |=> modem_out.dtr_n == !$past(wdata[0]) &&
      modem_out.rts_n == !$past(wdata[1])) else $error("terminal ready or send request level wrong");
   AST_AUX: assert property (mcr_wr && !wdata[4] |=> modem_out.aux_a_n == !$past(wdata[2]) &&
      modem_out.aux_b_n == !$past(wdata[3])) else $error("aux output level wrong");
   AST_LOOP_OUT: assert property (mcr_wr && wdata[4] |=> serial_tx_line && modem_out == 4'hf)
      else $error("loopback outputs not parked high");
   AST_RX_RST: assert property (fcr_wr && wdata[0] && wdata[1] |=> rx_fifo_reset ##1 !rx_fifo_reset)
      else $error("receive counter reset not a single pulse");
   AST_TX_RST: assert property (fcr_wr && wdata[0] && wdata[2] |=> tx_fifo_reset ##1 !tx_fifo_reset)
      else $error("transmit counter reset not a single pulse");
   AST_FCR_IGN: assert property (fcr_wr && !wdata[0] |=> !fifo_enable && !rx_fifo_reset && !tx_fifo_reset)
      else $error("control write without enable had effect");
   AST_DMA: assert property (fcr_wr && wdata[0] |=> dma_mode_select == $past(wdata[3]))
      else $error("dma mode select wrong");
   AST_IIR_TOP: assert property (iir_rd |=> rdata[7:6] == {2{$past(fifo_enable)}} && rdata[5:4] == 2'h0)
      else $error("ident upper bits wrong");
   AST_IIR_NONE: assert property (iir_rd && !irq_output |=> rdata[3:0] == 4'h1)
      else $error("ident shows pending with irq low");
   AST_RO_ZERO: assert property (rd && addr == 3'h4 |=> rdata[7:5] == 3'h0)
      else $error("modem control upper bits not zero");
   CVR_LOOP: cover property (mcr_wr && wdata[4]);
   CVR_FIFO_RST: cover property (fcr_wr && wdata[0] && wdata[1] && wdata[2]);
   CVR_IRQ_RD: cover property (iir_rd && irq_output);
endmodule
bind uart_ctl uart_ctl_props props (.clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .serial_tx_line,
   .fifo_enable, .rx_fifo_reset, .tx_fifo_reset, .dma_mode_select, .modem_out, .irq_output);
